// [design/aprs_device.sv]
// Power, reset and converter status registers of the sensor front end.
// Assumes one request at a time on the register port and a converter
// that presents each finished result with a one-cycle valid strobe.
//
// Overview of operation
// - Code C3 at reset register resets all but result data
// - Serial reset enable bit zero, clear after reset
// - Serial reset register locks after first write
// - Power codes: active, power-down, stand-by
// - Power readback shows mode in effect
// - Restart bit abandons conversion, starts anew
// - Policy bit lets full reset clear calibration
// - Bypass bit disables automatic clock detection
// - Clock select counts only under bypass
// - Excitation code maps to 100 uA steps
// - Ready register FF means no new result
// - Result high byte 1A, low 1B
// - Host spaces result reads 72 us apart
// - Scan config written only when not pending
// - Stale flag marks invalid or repeated read
module aprs_device (
  aprs_if.device     bus,
  input  wire logic         I_RESULT_VALID,
  input  wire logic  [15:0] I_RESULT,
  input  wire logic         I_SCAN_PENDING,
  input  wire logic         I_EXT_CLK_FOUND,
  output logic              O_RESTART,
  output logic              O_CONV_RESET,
  output logic              O_CAL_RESET,
  output logic       [1:0]  O_POWER_MODE,
  output logic              O_SERIAL_RESET_EN,
  output logic              O_DETECT_BYPASS,
  output logic              O_CLK_EXTERNAL,
  output logic       [3:0]  O_EXCITATION_CODE,
  output logic       [9:0]  O_EXCITATION_UA
);

  // Excitation current in uA; codes above the table give no current
  function automatic logic [9:0] exc_ua(input logic [3:0] code);
    logic [19:0] prod;
    prod = 20'({6'h00, code} * aprs_pkg::EXC_STEP_UA);
    if (code > aprs_pkg::EXC_CODE_MAX)
    begin
      exc_ua = 10'h000;
    end
    else
    begin
      exc_ua = prod[9:0];
    end
  endfunction

  // Register state
  logic        serial_en;      // Serial reset enable
  logic        serial_lock;    // Set by first write to serial control
  logic [1:0]  power_mode;     // Mode in effect
  logic [7:0]  aux;            // Auxiliary control, bit 7 kept zero
  logic [15:0] result;         // Latest conversion result
  logic        fresh;          // Result not yet read
  logic        stale;          // Last result read was stale
  logic        ack;
  logic [7:0]  rdata;
  logic        restart;
  logic        conv_reset;
  logic        cal_reset;
  logic        clk_ext;
  logic [9:0]  exc_cur;

  logic        next_serial_en;
  logic        next_serial_lock;
  logic [1:0]  next_power_mode;
  logic [7:0]  next_aux;
  logic [15:0] next_result;
  logic        next_fresh;
  logic        next_stale;
  logic        next_ack;
  logic [7:0]  next_rdata;
  logic        next_restart;
  logic        next_conv_reset;
  logic        next_cal_reset;
  logic        next_clk_ext;
  logic [9:0]  next_exc_cur;

  // Next-state logic for registers, answers and control pulses
  always_comb
  begin
    next_serial_en   = serial_en;
    next_serial_lock = serial_lock;
    next_power_mode  = power_mode;
    next_aux         = aux;
    next_result      = result;
    next_fresh       = fresh;
    next_stale       = stale;
    next_ack         = 1'b0;
    next_rdata       = rdata;
    next_restart     = 1'b0;
    next_conv_reset  = 1'b0;
    next_cal_reset   = 1'b0;

    // New result from the converter
    if (I_RESULT_VALID)
    begin
      next_result = I_RESULT;
      next_fresh  = 1'b1;
    end

    if (bus.req)
    begin
      next_ack = 1'b1;
      if (bus.we)
      begin
        case (bus.addr)
          aprs_pkg::ADDR_RESET_CMD:
          begin
            // Other codes are ignored
            if (bus.wdata == aprs_pkg::FULL_RESET_CODE)
            begin
              next_serial_en   = 1'b0;
              next_serial_lock = 1'b0;
              next_power_mode  = aprs_pkg::PWR_ACTIVE;
              next_aux         = aprs_pkg::AUX_RESET;
              next_fresh       = 1'b0;
              next_stale       = 1'b0;
              next_conv_reset  = 1'b1;
              // Policy sampled before the reset wipes it
              next_cal_reset   = aux[aprs_pkg::CAL_POLICY_BIT];
            end
          end
          aprs_pkg::ADDR_SERIAL_RESET:
          begin
            // Sticky: only the first write after reset lands
            if (!serial_lock)
            begin
              next_serial_en   = bus.wdata[aprs_pkg::SERIAL_EN_BIT];
              next_serial_lock = 1'b1;
            end
          end
          aprs_pkg::ADDR_POWER:
          begin
            // Code 2 is undefined, so the mode stays
            if (bus.wdata[1:0] != 2'h2)
            begin
              next_power_mode = bus.wdata[1:0];
            end
          end
          aprs_pkg::ADDR_RESTART:
          begin
            if (bus.wdata[aprs_pkg::RESTART_BIT])
            begin
              next_restart = 1'b1;
              // A result already held belongs to the abandoned run; one landing this cycle stays fresh
              next_fresh   = I_RESULT_VALID;
            end
          end
          aprs_pkg::ADDR_AUX:
          begin
            next_aux = bus.wdata & aprs_pkg::AUX_WRITE_MASK;
          end
          default:
          begin
            // Read-only and unmapped addresses: write dropped
            next_aux = aux;
          end
        endcase
      end
      else
      begin
        case (bus.addr)
          aprs_pkg::ADDR_SERIAL_RESET:
            next_rdata = {7'h00, serial_en};
          aprs_pkg::ADDR_POWER:
            next_rdata = {6'h00, power_mode};
          aprs_pkg::ADDR_AUX:
            next_rdata = aux;
          aprs_pkg::ADDR_RESULT_READY:
            next_rdata = fresh ? aprs_pkg::READY_NEW
                               : aprs_pkg::READY_NONE;
          aprs_pkg::ADDR_RESULT_HIGH:
            next_rdata = result[15:8];
          aprs_pkg::ADDR_RESULT_LOW:
            next_rdata = result[7:0];
          aprs_pkg::ADDR_CHAN_STATUS:
            next_rdata = {6'h00, I_SCAN_PENDING, stale};
          default:
            next_rdata = 8'h00;
        endcase
        // Judge each result byte read against freshness
        if ((bus.addr == aprs_pkg::ADDR_RESULT_HIGH) ||
            (bus.addr == aprs_pkg::ADDR_RESULT_LOW))
        begin
          next_stale = ~fresh;
        end
        // Low byte finishes the word; a result landing now survives
        if ((bus.addr == aprs_pkg::ADDR_RESULT_LOW) && !I_RESULT_VALID)
        begin
          next_fresh = 1'b0;
        end
      end
    end

    // Clock choice: detector unless bypassed, then select bit
    if (next_aux[aprs_pkg::DETECT_BYPASS_BIT])
    begin
      next_clk_ext = next_aux[aprs_pkg::CLK_SEL_BIT];
    end
    else
    begin
      next_clk_ext = I_EXT_CLK_FOUND;
    end
    next_exc_cur = exc_ua(next_aux[3:0]);
  end

  // State registers
  always_ff @(posedge bus.clk or negedge bus.rst_n)
  begin
    if (!bus.rst_n)
    begin
      serial_en   <= aprs_pkg::SERIAL_RESET_VAL[0];
      serial_lock <= 1'b0;
      power_mode  <= aprs_pkg::PWR_ACTIVE;
      aux         <= aprs_pkg::AUX_RESET;
      result      <= 16'h0000;
      fresh       <= 1'b0;
      stale       <= 1'b0;
      ack         <= 1'b0;
      rdata       <= 8'h00;
      restart     <= 1'b0;
      conv_reset  <= 1'b0;
      cal_reset   <= 1'b0;
      clk_ext     <= 1'b0;
      exc_cur     <= 10'h000;
    end
    else
    begin
      serial_en   <= next_serial_en;
      serial_lock <= next_serial_lock;
      power_mode  <= next_power_mode;
      aux         <= next_aux;
      result      <= next_result;
      fresh       <= next_fresh;
      stale       <= next_stale;
      ack         <= next_ack;
      rdata       <= next_rdata;
      restart     <= next_restart;
      conv_reset  <= next_conv_reset;
      cal_reset   <= next_cal_reset;
      clk_ext     <= next_clk_ext;
      exc_cur     <= next_exc_cur;
    end
  end

  // Outputs straight from flip-flops
  assign bus.ack           = ack;
  assign bus.rdata         = rdata;
  assign O_RESTART         = restart;
  assign O_CONV_RESET      = conv_reset;
  assign O_CAL_RESET       = cal_reset;
  assign O_POWER_MODE      = power_mode;
  assign O_SERIAL_RESET_EN = serial_en;
  assign O_DETECT_BYPASS   = aux[aprs_pkg::DETECT_BYPASS_BIT];
  assign O_CLK_EXTERNAL    = clk_ext;
  assign O_EXCITATION_CODE = aux[3:0];
  assign O_EXCITATION_UA   = exc_cur;

endmodule

// [design/aprs_host.sv]
// Controller end: takes orders from software over AXI4-Lite and runs
// them on the register port. Assumes the device answers every request.
module aprs_host #(
  parameter int GAP_CYC = aprs_pkg::RESULT_GAP_CYC
) (
  aprs_if.host       bus,
  input  wire logic         I_AWVALID,
  output logic              O_AWREADY,
  input  wire logic  [7:0]  I_AWADDR,
  input  wire logic         I_WVALID,
  output logic              O_WREADY,
  input  wire logic  [31:0] I_WDATA,
  input  wire logic  [3:0]  I_WSTRB,
  output logic              O_BVALID,
  input  wire logic         I_BREADY,
  output logic       [1:0]  O_BRESP,
  input  wire logic         I_ARVALID,
  output logic              O_ARREADY,
  input  wire logic  [7:0]  I_ARADDR,
  output logic              O_RVALID,
  input  wire logic         I_RREADY,
  output logic       [31:0] O_RDATA,
  output logic       [1:0]  O_RRESP,
  output logic              O_IRQ
);
  // Order sequencer states
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_CHECK = 3'b001, H_POLL = 3'b010,
    H_WAIT = 3'b011
  } aprs_hstate_t;

  aprs_hstate_t st, next_st;
  logic [7:0]  aw_addr, next_aw_addr;   // Held write address
  logic        aw_held, next_aw_held;
  logic [31:0] w_data, next_w_data;     // Held write data
  logic [3:0]  w_strb, next_w_strb;
  logic        w_held, next_w_held;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        rvalid, next_rvalid;
  logic [31:0] rdat, next_rdat;
  logic [1:0]  rresp, next_rresp;
  logic [16:0] cmd, next_cmd;           // {write, data, addr}
  logic        scan_ok, next_scan_ok;   // Pending bit seen clear
  logic [7:0]  last_rd, next_last_rd;
  logic [1:0]  irq_st, next_irq_st;
  logic [1:0]  irq_mask, next_irq_mask;
  logic        irq, next_irq;
  logic [15:0] gap, next_gap;           // Result read spacing
  logic        req, next_req;
  logic        we, next_we;
  logic [7:0]  addr, next_addr;
  logic [7:0]  wdata, next_wdata;
  logic        busy;
  logic        is_result;
  logic        done_evt;                // Order answered this cycle

  assign busy      = (st != H_IDLE);
  assign done_evt  = (st == H_WAIT) && bus.ack;
  assign is_result = (cmd[7:0] == aprs_pkg::ADDR_RESULT_HIGH) ||
                     (cmd[7:0] == aprs_pkg::ADDR_RESULT_LOW);

  // Bus slave, software registers and order sequencer
  always_comb
  begin
    next_st = st;  next_aw_addr = aw_addr;  next_aw_held = aw_held;
    next_w_data = w_data;  next_w_strb = w_strb;  next_w_held = w_held;
    next_bvalid = bvalid;  next_bresp = bresp;  next_rvalid = rvalid;
    next_rdat = rdat;  next_rresp = rresp;  next_cmd = cmd;
    next_scan_ok = scan_ok;  next_last_rd = last_rd;
    next_irq_st = irq_st;  next_irq_mask = irq_mask;
    next_gap = (gap != 16'h0000) ? gap - 16'h0001 : gap;
    next_req = 1'b0;  next_we = we;  next_addr = addr;  next_wdata = wdata;

    // Address and data taken in either order
    if (I_AWVALID && O_AWREADY)
    begin
      next_aw_addr = I_AWADDR;
      next_aw_held = 1'b1;
    end
    if (I_WVALID && O_WREADY)
    begin
      next_w_data = I_WDATA;
      next_w_strb = I_WSTRB;
      next_w_held = 1'b1;
    end
    if (bvalid && I_BREADY)
    begin
      next_bvalid = 1'b0;
    end
    // Sequencer events, set before software clears so set wins
    case (st)
      H_IDLE:
        next_st = H_IDLE;
      H_CHECK:
      begin
        if ((cmd[7:0] == aprs_pkg::ADDR_SCAN_CONFIG) && cmd[16] &&
            !scan_ok)
        begin
          // Ask for channel status before touching scan config
          next_req = 1'b1;  next_we = 1'b0;
          next_addr = aprs_pkg::ADDR_CHAN_STATUS;
          next_st = H_POLL;
        end
        else if (!(is_result && !cmd[16] && gap != 16'h0000))
        begin
          next_req = 1'b1;  next_we = cmd[16];
          next_addr = cmd[7:0];  next_wdata = cmd[15:8];
          next_st = H_WAIT;
        end
      end
      H_POLL:
        if (bus.ack)
        begin
          next_scan_ok = ~bus.rdata[aprs_pkg::SCAN_PENDING_BIT];
          next_st = H_CHECK;
        end
      H_WAIT:
        if (bus.ack)
        begin
          if (!cmd[16])
          begin
            next_last_rd = bus.rdata;
          end
          if (is_result && !cmd[16])
          begin
            next_gap = 16'(GAP_CYC);
          end
          next_irq_st[aprs_pkg::IRQ_DONE_BIT] = 1'b1;
          next_st = H_IDLE;
        end
      default:
        next_st = H_IDLE;
    endcase

    // Complete a write once address and data are both held
    if (aw_held && w_held && !bvalid)
    begin
      next_aw_held = 1'b0;  next_w_held = 1'b0;
      next_bvalid = 1'b1;  next_bresp = aprs_pkg::RESP_OKAY;
      case (aw_addr)
        aprs_pkg::HOFS_COMMAND:
          if (!busy && (w_strb == 4'hF))
          begin
            // Power code 2 is not a mode: refuse it here
            if ((w_data[7:0] == aprs_pkg::ADDR_POWER) && w_data[16] &&
                (w_data[9:8] == 2'h2))
            begin
              next_irq_st[aprs_pkg::IRQ_REFUSED_BIT] = 1'b1;
            end
            else
            begin
              next_cmd = w_data[16:0];  next_scan_ok = 1'b0;
              next_st = H_CHECK;
            end
          end
        aprs_pkg::HOFS_IRQ_STATUS:
          // Write one to clear; a done event this cycle outlives it
          next_irq_st = next_irq_st & ~(w_data[1:0] & {1'b1, !done_evt});
        aprs_pkg::HOFS_IRQ_MASK:
          next_irq_mask = w_data[1:0];
        aprs_pkg::HOFS_STATUS, aprs_pkg::HOFS_READ_DATA:
          next_bresp = aprs_pkg::RESP_OKAY;
        default:
          next_bresp = aprs_pkg::RESP_SLVERR;
      endcase
    end

    // Read channel, one beat per address
    if (rvalid && I_RREADY)
    begin
      next_rvalid = 1'b0;
    end
    if (I_ARVALID && O_ARREADY)
    begin
      next_rvalid = 1'b1;  next_rresp = aprs_pkg::RESP_OKAY;
      case (I_ARADDR)
        aprs_pkg::HOFS_COMMAND:    next_rdat = {15'h0000, cmd};
        aprs_pkg::HOFS_STATUS:     next_rdat = {31'h0000_0000, busy};
        aprs_pkg::HOFS_READ_DATA:  next_rdat = {24'h00_0000, last_rd};
        aprs_pkg::HOFS_IRQ_STATUS: next_rdat = {30'h0000_0000, irq_st};
        aprs_pkg::HOFS_IRQ_MASK:   next_rdat = {30'h0000_0000, irq_mask};
        default:
        begin
          next_rdat = 32'h0000_0000;
          next_rresp = aprs_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_irq = |(next_irq_st & next_irq_mask);
  end

  // Registers only
  always_ff @(posedge bus.clk or negedge bus.rst_n)
  begin
    if (!bus.rst_n)
    begin
      st <= H_IDLE;  aw_addr <= 8'h00;  aw_held <= 1'b0;
      w_data <= 32'h0000_0000;  w_strb <= 4'h0;  w_held <= 1'b0;
      bvalid <= 1'b0;  bresp <= 2'h0;  rvalid <= 1'b0;
      rdat <= 32'h0000_0000;  rresp <= 2'h0;  cmd <= 17'h0_0000;
      scan_ok <= 1'b0;  last_rd <= 8'h00;  irq_st <= 2'h0;
      irq_mask <= 2'h0;  irq <= 1'b0;  gap <= 16'h0000;
      req <= 1'b0;  we <= 1'b0;  addr <= 8'h00;  wdata <= 8'h00;
    end
    else
    begin
      st <= next_st;  aw_addr <= next_aw_addr;  aw_held <= next_aw_held;
      w_data <= next_w_data;  w_strb <= next_w_strb;
      w_held <= next_w_held;  bvalid <= next_bvalid;  bresp <= next_bresp;
      rvalid <= next_rvalid;  rdat <= next_rdat;  rresp <= next_rresp;
      cmd <= next_cmd;  scan_ok <= next_scan_ok;  last_rd <= next_last_rd;
      irq_st <= next_irq_st;  irq_mask <= next_irq_mask;  irq <= next_irq;
      gap <= next_gap;  req <= next_req;  we <= next_we;
      addr <= next_addr;  wdata <= next_wdata;
    end
  end

  // Ready flags registered, so the accept is one cycle behind
  logic awready, wready, arready;
  always_ff @(posedge bus.clk or negedge bus.rst_n)
  begin
    if (!bus.rst_n)
    begin
      awready <= 1'b0;  wready <= 1'b0;  arready <= 1'b0;
    end
    else
    begin
      awready <= !next_aw_held && !next_bvalid && !(I_AWVALID && awready);
      wready  <= !next_w_held && !next_bvalid && !(I_WVALID && wready);
      arready <= !next_rvalid && !(I_ARVALID && arready);
    end
  end

  assign O_AWREADY = awready;  assign O_WREADY = wready;
  assign O_ARREADY = arready;  assign O_BVALID = bvalid;
  assign O_BRESP = bresp;  assign O_RVALID = rvalid;
  assign O_RDATA = rdat;  assign O_RRESP = rresp;  assign O_IRQ = irq;
  assign bus.req = req;  assign bus.we = we;
  assign bus.addr = addr;  assign bus.wdata = wdata;
endmodule

// [design/aprs_if.sv]
// Register port between the controller and the front end registers.
// Assumes both ends share one clock and one reset.
interface aprs_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic       req;    // One-cycle request strobe
  logic       we;     // Write when high, read when low
  logic [7:0] addr;   // Register address
  logic [7:0] wdata;  // Write byte
  logic       ack;    // One-cycle answer strobe
  logic [7:0] rdata;  // Read byte, valid with ack

  modport device (input clk, rst_n, req, we, addr, wdata,
                  output ack, rdata);
  modport host   (input clk, rst_n, ack, rdata,
                  output req, we, addr, wdata);
endinterface

// [design/aprs_pkg.sv]
// Shared constants for the sensor front end register group and its
// controller. Assumes nothing beyond a SystemVerilog compiler.
package aprs_pkg;
  // Device register addresses on the register port
  localparam logic [7:0] ADDR_RESET_CMD     = 8'h00;
  localparam logic [7:0] ADDR_SERIAL_RESET  = 8'h02;
  localparam logic [7:0] ADDR_POWER         = 8'h08;
  localparam logic [7:0] ADDR_RESTART       = 8'h0B;
  localparam logic [7:0] ADDR_AUX           = 8'h12;
  localparam logic [7:0] ADDR_RESULT_READY  = 8'h18;
  localparam logic [7:0] ADDR_RESULT_HIGH   = 8'h1A;
  localparam logic [7:0] ADDR_RESULT_LOW    = 8'h1B;
  localparam logic [7:0] ADDR_CHAN_STATUS   = 8'h1E;
  localparam logic [7:0] ADDR_SCAN_CONFIG   = 8'h1F;
  // Codes and field layout
  localparam logic [7:0] FULL_RESET_CODE    = 8'hC3;
  localparam logic [1:0] PWR_ACTIVE         = 2'h0;
  localparam logic [1:0] PWR_DOWN           = 2'h1;
  localparam logic [1:0] PWR_STANDBY        = 2'h3;
  localparam int         SERIAL_EN_BIT      = 0;
  localparam int         RESTART_BIT        = 0;
  localparam int         CAL_POLICY_BIT     = 6;
  localparam int         DETECT_BYPASS_BIT  = 5;
  localparam int         CLK_SEL_BIT        = 4;
  localparam int         SCAN_PENDING_BIT   = 1;
  localparam int         STALE_BIT          = 0;
  localparam logic [7:0] AUX_WRITE_MASK     = 8'h7F;
  localparam logic [7:0] AUX_RESET          = 8'h00;
  localparam logic [7:0] SERIAL_RESET_VAL   = 8'h00;
  localparam logic [3:0] EXC_CODE_MAX       = 4'hA;
  localparam logic [9:0] EXC_STEP_UA        = 10'h064;
  localparam logic [7:0] READY_NONE         = 8'hFF;
  localparam logic [7:0] READY_NEW          = 8'h00;
  // Timing: least spacing of result reads
  localparam int CLK_PERIOD_NS   = 50;
  localparam int RESULT_GAP_NS   = 72000;
  localparam int RESULT_GAP_CYC  =
    (RESULT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Controller register byte offsets on the software bus
  localparam logic [7:0] HOFS_COMMAND       = 8'h00;
  localparam logic [7:0] HOFS_STATUS        = 8'h04;
  localparam logic [7:0] HOFS_READ_DATA     = 8'h08;
  localparam logic [7:0] HOFS_IRQ_STATUS    = 8'h0C;
  localparam logic [7:0] HOFS_IRQ_MASK      = 8'h10;
  localparam int         CMD_WRITE_BIT      = 16;
  localparam int         IRQ_DONE_BIT       = 0;
  localparam int         IRQ_REFUSED_BIT    = 1;
  localparam logic [1:0] RESP_OKAY          = 2'h0;
  localparam logic [1:0] RESP_SLVERR        = 2'h2;
endpackage

// [verification/aprs_assertions.sv]
// Checks the register port between the controller and the device.
// Assumes one clock and an asynchronous active-low reset.
module aprs_assertions #(
  parameter int GAP_CYC = aprs_pkg::RESULT_GAP_CYC
) (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       req,
  input wire logic       we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Read of one address, answered next cycle
  sequence rd_of(logic [7:0] a);
    req && !we && addr == a;
  endsequence
  ack_follows_req_a: assert property (req |=> ack && !req)
    else $error("request not answered next cycle");
  ack_needs_req_a: assert property (ack |-> $past(req))
    else $error("answer without request");
  wo_reads_zero_a: assert property ((rd_of(8'h00) or rd_of(8'h0B)) |=>
    rdata == 8'h00) else $error("write-only place read nonzero");
  serial_bits_a: assert property (rd_of(8'h02) |=> rdata[7:1] == 0)
    else $error("serial reset reserved bits set");
  power_code_a: assert property (rd_of(8'h08) |=> rdata != 8'h02 &&
    rdata[7:2] == 0) else $error("power readback illegal");
  aux_top_a: assert property (rd_of(8'h12) |=> !rdata[7])
    else $error("aux reserved bit set");
  status_bits_a: assert property (rd_of(8'h1E) |=> rdata[7:2] == 0)
    else $error("status reserved bits set");
  ready_code_a: assert property (rd_of(8'h18) |=>
    rdata == 8'h00 || rdata == 8'hFF) else $error("ready code illegal");
  // Result byte reads spaced by the gap, counted from the last answer
  logic res_rd;     // Result byte read requested
  logic res_ack;    // Answer cycle of a result byte read
  int   since_res;  // Cycles since that answer, saturating
  assign res_rd = req && !we && (addr == 8'h1A || addr == 8'h1B);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      res_ack   <= 1'b0;
      since_res <= GAP_CYC;
    end
    else
    begin
      res_ack <= res_rd;
      if (res_ack)
        since_res <= 0;
      else if (since_res < GAP_CYC)
        since_res <= since_res + 1;
    end
  end
  result_gap_a: assert property (res_rd |->
    since_res >= GAP_CYC) else $error("result reads too close");
endmodule

// [verification/aprs_tb_top.sv]
// Bench for controller and device joined by the register port.
// Assumes GAP_CYC shortened to 40 cycles; software side is AXI4-Lite.
module afe_power_reset_adc_status_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Short enough to run fast, long enough that the host must wait
  localparam int GAP = 40;
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  err_count++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
  logic        I_CLK, I_RST_N, awv, wv, bry, arv, rry, rvl, scan, ext;
  logic [7:0]  awa, ara, r, v;
  logic [31:0] wd, rd;
  logic [15:0] res;
  logic [1:0]  rsp, pexp;
  wire         awr, wr, bv, arr, rvd, irq, rst, cnv, cal, ser, byp, cex;
  wire  [1:0]  brsp, rrsp, pm;
  wire  [31:0] rdat;
  wire  [3:0]  exc;
  wire  [9:0]  ua;
  int          err_count, check_count, cyc, n_rst, n_cnv, n_cal;
  int          seed = 57;
  aprs_if bus (.clk(I_CLK), .rst_n(I_RST_N));
  aprs_host #(.GAP_CYC(GAP)) i_aprs_host (.bus(bus), .I_AWVALID(awv),
    .O_AWREADY(awr), .I_AWADDR(awa), .I_WVALID(wv), .O_WREADY(wr),
    .I_WDATA(wd), .I_WSTRB(4'hF), .O_BVALID(bv), .I_BREADY(bry),
    .O_BRESP(brsp), .I_ARVALID(arv), .O_ARREADY(arr), .I_ARADDR(ara),
    .O_RVALID(rvd), .I_RREADY(rry), .O_RDATA(rdat), .O_RRESP(rrsp),
    .O_IRQ(irq));
  aprs_device i_aprs_device (.bus(bus), .I_RESULT_VALID(rvl),
    .I_RESULT(res), .I_SCAN_PENDING(scan), .I_EXT_CLK_FOUND(ext),
    .O_RESTART(rst), .O_CONV_RESET(cnv), .O_CAL_RESET(cal),
    .O_POWER_MODE(pm), .O_SERIAL_RESET_EN(ser), .O_DETECT_BYPASS(byp),
    .O_CLK_EXTERNAL(cex), .O_EXCITATION_CODE(exc), .O_EXCITATION_UA(ua));
  aprs_assertions #(.GAP_CYC(GAP)) i_aprs_assertions (.clk(bus.clk),
    .rst_n(bus.rst_n),
    .req(bus.req), .we(bus.we), .addr(bus.addr), .wdata(bus.wdata),
    .ack(bus.ack), .rdata(bus.rdata));
  initial
  begin
    I_CLK = 0;
    forever #25 I_CLK = ~I_CLK;
  end
  // Pulse counters; outputs last one cycle, so count them
  always @(posedge I_CLK)
  begin
    n_rst += rst;
    n_cnv += cnv;
    n_cal += cal;
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      conclude();
    end
  end
  // Expected current: codes past the top step give none
  function automatic logic [9:0] exp_ua(input logic [3:0] c);
    return (c <= 4'hA) ? c * 10'h064 : 10'h000;
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLK);
    {awv, wv, bry, awa, wd} <= {3'b111, a, d};
    // Each channel dropped at the edge where its ready is seen high
    do
    begin
      @(posedge I_CLK);
      if (awv && awr) awv <= 0;
      if (wv && wr) wv <= 0;
    end
    while ((awv && !awr) || (wv && !wr));
    do @(posedge I_CLK); while (!bv);
    bry <= 0;
    rsp = brsp;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge I_CLK);
    {arv, rry, ara} <= {2'b11, a};
    do @(posedge I_CLK); while (!arr);
    arv <= 0;
    do @(posedge I_CLK); while (!rvd);
    rry <= 0;
    {rd, rsp} = {rdat, rrsp};
  endtask
  task automatic dev_go(input logic [7:0] a, d, input logic w);
    axi_wr(8'h00, {15'h0000, w, d, a});
  endtask
  // Busy poll; a hang is caught by the cycle ceiling
  task automatic dev_end();
    do axi_rd(8'h04); while (rd[0] !== 1'b0);
    axi_rd(8'h08);
    r = rd[7:0];
  endtask
  task automatic dev_w(input logic [7:0] a, d);
    dev_go(a, d, 1'b1);
    dev_end();
  endtask
  task automatic chk_rd(input logic [7:0] a, e);
    dev_go(a, 8'h00, 1'b0);
    dev_end();
    `CHK(r, e)
  endtask
  task automatic new_result();
    @(posedge I_CLK);
    {rvl, res} <= {1'b1, 16'($random(seed))};
    @(posedge I_CLK);
    rvl <= 0;
  endtask
  initial
  begin
    {I_RST_N, awv, wv, bry, arv, rry, rvl, scan, ext} = 0;
    {awa, ara, wd, res, pexp} = 0;
    repeat (20) @(posedge I_CLK);
    I_RST_N <= 1;
    repeat (2) @(posedge I_CLK);
    axi_wr(8'h10, 32'h0000_0003);
    chk_rd(8'h02, 8'h00);
    chk_rd(8'h12, 8'h00);
    chk_rd(8'h08, 8'h00);
    chk_rd(8'h00, 8'h00);
    chk_rd(8'h0B, 8'h00);
    // Codes with random reserved bits; code 2 keeps the mode
    for (int i = 0; i < 4; i++)
    begin
      v = 8'($random(seed)) & 8'hFC | 8'((i * 3 + 1) % 4);
      dev_w(8'h08, v);
      if (v[1:0] != 2'h2) pexp = v[1:0];
      chk_rd(8'h08, {6'h00, pexp});
      `CHK(pm, pexp)
    end
    axi_rd(8'h0C);
    `CHK(rd[1], 1'b1)
    `CHK(irq, 1'b1)
    axi_wr(8'h10, 32'h0000_0000);
    repeat (3) @(posedge I_CLK);
    `CHK(irq, 1'b0)
    axi_wr(8'h0C, 32'h0000_0003);
    axi_rd(8'h0C);
    `CHK(rd[1:0], 2'h0)
    dev_w(8'h02, 8'h01);
    dev_w(8'h02, 8'h00);
    chk_rd(8'h02, 8'h01);
    `CHK(ser, 1'b1)
    dev_w(8'h00, 8'($random(seed)) | 8'h04);
    chk_rd(8'h02, 8'h01);
    dev_w(8'h12, 8'h40);
    dev_w(8'h00, 8'hC3);
    chk_rd(8'h02, 8'h00);
    `CHK(pm, 2'h0)
    `CHK({n_cnv, n_cal}, {32'd1, 32'd1})
    dev_w(8'h00, 8'hC3);
    `CHK({n_cnv, n_cal}, {32'd2, 32'd1})
    for (int i = 0; i < 6; i++)
    begin
      v = (i == 0) ? 8'hAA : (i == 1) ? 8'h1B : 8'($random(seed));
      ext <= i[0];
      dev_w(8'h12, v);
      chk_rd(8'h12, v & 8'h7F);
      `CHK({byp, exc}, {v[5], v[3:0]})
      `CHK(cex, v[5] ? v[4] : i[0])
      `CHK(ua, exp_ua(v[3:0]))
    end
    new_result();
    chk_rd(8'h18, 8'h00);
    chk_rd(8'h1A, res[15:8]);
    chk_rd(8'h1E, 8'h00);
    chk_rd(8'h1B, res[7:0]);
    chk_rd(8'h1B, res[7:0]);
    chk_rd(8'h1E, 8'h01);
    chk_rd(8'h18, 8'hFF);
    new_result();
    dev_w(8'h0B, 8'h01);
    chk_rd(8'h18, 8'hFF);
    `CHK(n_rst, 1)
    scan <= 1;
    chk_rd(8'h1E, 8'h03);
    dev_go(8'h1F, 8'h30, 1'b1);
    repeat (40) @(posedge I_CLK);
    axi_rd(8'h04);
    `CHK(rd[0], 1'b1)
    scan <= 0;
    dev_end();
    axi_rd(8'h40);
    `CHK({rsp, rd}, {2'h2, 32'h0000_0000})
    axi_wr(8'h40, 32'h0000_0000);
    `CHK(rsp, 2'h2)
    conclude();
  end
endmodule
